// [hdl/rsf_params.svh]
// Summary of operation
// (RULE1) Event counter registers reset to 00H
// (RULE2) Interval timer and carrier registers reset 00H
// (RULE3) Watch mode and clock output reset 00H
// (RULE4) Watchdog enable loads 1AH or 9AH
// (RULE5) Converter result and control registers reset zero
// (RULE6) First UART loads FFH, 01H, 00H, 1FH
// (RULE7) Second UART loads FFH, 01H, 16H, 00H
// (RULE8) Clocked serial port registers reset 00H
// (RULE9) Auto port divisor 03H, others 00H
// (RULE10) Two-wire port registers reset 00H
// (RULE11) Multiplier/divider registers reset to zero
// (RULE12) Key return mode resets 00H
// (RULE13) Irq flags, edges 00H; masks, priorities FFH
// (RULE14) Values held unchanged after reset release
// (RULE15) Watchdog flag: pin/power clear, watchdog sets
// (RULE16) Low-voltage flag set by detector, watchdog holds
// (RULE17) Low-voltage registers cleared except by detector
// (RULE18) Flag register cleared by pin, power, read
// (RULE19) Values loaded synchronously, visible after release
`ifndef RSF_PARAMS_SVH
`define RSF_PARAMS_SVH

// ==========================================================
// Register indices
`define RSF_EVT_BASE 7'h00
`define RSF_INTV_BASE 7'h08
`define RSF_WATCH_MODE 7'h0f
`define RSF_CLK_OUT_SEL 7'h10
`define RSF_WATCHDOG_ENABLE_REG 7'h11
`define RSF_CONV_BASE 7'h12
`define RSF_UARTA_RX 7'h18
`define RSF_UARTA_TXS 7'h19
`define RSF_UARTA_MODE 7'h1a
`define RSF_UARTA_ERR 7'h1b
`define RSF_UARTA_BAUD 7'h1c
`define RSF_UARTB_RX 7'h1d
`define RSF_UARTB_TX 7'h1e
`define RSF_UARTB_MODE 7'h1f
`define RSF_UARTB_ERR 7'h20
`define RSF_UARTB_TXST 7'h21
`define RSF_UARTB_CLK 7'h22
`define RSF_UARTB_BAUD 7'h23
`define RSF_UARTB_CTRL 7'h24
`define RSF_ISC 7'h25
`define RSF_SYNC_BASE 7'h26
`define RSF_AUTO_BASE 7'h2e
`define RSF_AUTO_DIVISOR 7'h31
`define RSF_TWOWIRE_BASE 7'h36
`define RSF_MULDIV_BASE 7'h3d
`define RSF_KEY_MODE 7'h44
`define RSF_IRQ_REQ_BASE 7'h45
`define RSF_IRQ_MASK_BASE 7'h49
`define RSF_IRQ_PRIO_BASE 7'h4d
`define RSF_EDGE_BASE 7'h51
`define RSF_GEN_LAST 7'h52
`define RSF_RESET_SOURCE_FLAGS_IDX 7'h53
`define RSF_LOWVOLT_CONTROL_IDX 7'h54
`define RSF_LOWVOLT_LEVEL_SEL_IDX 7'h55

// ==========================================================
// Reset values and fields
`define RSF_ZERO 8'h00
`define RSF_WATCHDOG_ENABLE_REG_VAL_A 8'h1a
`define RSF_WATCHDOG_ENABLE_REG_VAL_B 8'h9a
`define RSF_UART_BUF_VAL 8'hff
`define RSF_UART_MODE_VAL 8'h01
`define RSF_UARTA_BAUD_VAL 8'h1f
`define RSF_UARTB_BAUD_VAL 8'hff
`define RSF_UARTB_CTRL_VAL 8'h16
`define RSF_AUTO_DIV_VAL 8'h03
`define RSF_IRQ_MASK_VAL 8'hff
`define RSF_WATCHDOG_RESET_FLAG_BIT 4
`define RSF_LOWVOLT_RESET_FLAG_BIT 0

`endif

// [hdl/rsf_pkg.sv]
package rsf_pkg;
`include "rsf_params.svh"

	typedef logic [6:0] rsf_idx_t;
	typedef logic [7:0] rsf_byte_t;

	typedef struct packed {
		rsf_byte_t [`RSF_GEN_LAST:0] gen;
		logic wdt_flag;
		logic lvi_flag;
		rsf_byte_t lv_ctrl;
		rsf_byte_t lv_level;
		rsf_byte_t rd_data;
		logic rst_active;
	} rsf_state_s;

	typedef struct packed {
		logic [2:0] s1;
		logic [2:0] s2;
		logic [2:0] s3;
		logic [2:0] out;
	} rsf_sync_s;
endpackage

// [hdl/rsf_reset_values.sv]
`timescale 1ns/100ps
`include "rsf_params.svh"
module rsf_reset_values (
	input wire logic CORE_CLK,
	input wire logic SRST,
	input wire logic PIN_RESET,
	input wire logic POWER_ON_CLEAR,
	input wire logic WATCHDOG_UNIT,
	input wire logic LOWVOLT_DETECTOR,
	input wire logic WATCHDOG_ENABLE_REG_OPTION,
	input wire logic WR_EN,
	input wire logic [6:0] WR_IDX,
	input wire logic [7:0] WR_DATA,
	input wire logic RD_EN,
	input wire logic [6:0] RD_IDX,
	output logic [7:0] RD_DATA,
	output logic RESET_ACTIVE,
	output logic WATCHDOG_RESET_FLAG,
	output logic LOWVOLT_RESET_FLAG,
	output logic [7:0] LOWVOLT_CONTROL,
	output logic [7:0] LOWVOLT_LEVEL_SEL
);
	rsf_pkg::rsf_state_s s_q;
	rsf_pkg::rsf_state_s s_d;
	logic [4:0] src_sync;
	logic pin_s;
	logic poc_s;
	logic wdt_s;
	logic lvi_s;
	logic opt_s;
	logic rst_any;
	logic clear_src;

	// ======================================================
	// Source capture; option strap shares the filter
	rsf_sync #(
		.WIDTH(5)
	) u_sync (
		.clk(CORE_CLK),
		.srst(SRST),
		.async_in({WATCHDOG_ENABLE_REG_OPTION, LOWVOLT_DETECTOR, WATCHDOG_UNIT,
			POWER_ON_CLEAR, PIN_RESET}),
		.sync_out(src_sync)
	);

	assign pin_s = src_sync[0];
	assign poc_s = src_sync[1];
	assign wdt_s = src_sync[2];
	assign lvi_s = src_sync[3];
	assign opt_s = src_sync[4];

	// ======================================================
	// Reset value per register index
	function automatic rsf_pkg::rsf_byte_t rst_val(
		input rsf_pkg::rsf_idx_t idx,
		input logic opt
	);
		rst_val = `RSF_ZERO; // [RULE1] [RULE2] [RULE3] [RULE5] [RULE8]
		// Masks and priorities sit back to back, both all ones
		if (idx >= `RSF_IRQ_MASK_BASE && idx < `RSF_EDGE_BASE) begin
			rst_val = `RSF_IRQ_MASK_VAL; // [RULE13]
		end
		case (idx)
			`RSF_WATCHDOG_ENABLE_REG: begin
				rst_val = opt ? `RSF_WATCHDOG_ENABLE_REG_VAL_B : `RSF_WATCHDOG_ENABLE_REG_VAL_A; // [RULE4]
			end
			`RSF_UARTA_RX, `RSF_UARTA_TXS: begin
				rst_val = `RSF_UART_BUF_VAL; // [RULE6]
			end
			`RSF_UARTA_MODE, `RSF_UARTB_MODE: begin
				rst_val = `RSF_UART_MODE_VAL; // [RULE6] [RULE7]
			end
			`RSF_UARTA_BAUD: begin
				rst_val = `RSF_UARTA_BAUD_VAL; // [RULE6]
			end
			`RSF_UARTB_RX, `RSF_UARTB_TX: begin
				rst_val = `RSF_UART_BUF_VAL; // [RULE7]
			end
			`RSF_UARTB_BAUD: begin
				rst_val = `RSF_UARTB_BAUD_VAL; // [RULE7]
			end
			`RSF_UARTB_CTRL: begin
				rst_val = `RSF_UARTB_CTRL_VAL; // [RULE7]
			end
			`RSF_AUTO_DIVISOR: begin
				rst_val = `RSF_AUTO_DIV_VAL; // [RULE9]
			end
			default: begin
			end
		endcase
		// Two-wire, muldiv, key and request flags keep zero
		// [RULE10] [RULE11] [RULE12]
	endfunction

	function automatic rsf_pkg::rsf_byte_t flag_byte(
		input logic wdt,
		input logic lowvolt_detector
	);
		flag_byte = `RSF_ZERO;
		flag_byte[`RSF_WATCHDOG_RESET_FLAG_BIT] = wdt;
		flag_byte[`RSF_LOWVOLT_RESET_FLAG_BIT] = lowvolt_detector;
	endfunction

	// ======================================================
	// Next state
	assign rst_any = SRST | pin_s | poc_s | wdt_s | lvi_s;
	// Power-up reset of this block counts as power-on clear
	assign clear_src = SRST | pin_s | poc_s;

	always_comb begin
		s_d = s_q;
		s_d.rst_active = rst_any;
		if (rst_any) begin
			// Reloaded every cycle so release shows them at once
			for (int i = 0; i <= int'(`RSF_GEN_LAST); i++) begin
				s_d.gen[i] = rst_val(7'(i), opt_s); // [RULE19] [RULE14]
			end
			s_d.rd_data = `RSF_ZERO;
			if (clear_src) begin
				s_d.wdt_flag = 1'b0; // [RULE15] [RULE18]
				s_d.lvi_flag = 1'b0; // [RULE18]
			end
			// Sets applied last so they win over a coincident clear
			if (wdt_s) begin
				s_d.wdt_flag = 1'b1; // [RULE15]
			end
			if (lvi_s) begin
				s_d.lvi_flag = 1'b1; // [RULE16]
			end
			// A detector-only reset leaves its own settings intact
			if (clear_src | wdt_s) begin
				s_d.lv_ctrl = `RSF_ZERO; // [RULE17]
				s_d.lv_level = `RSF_ZERO; // [RULE17]
			end
		end else begin
			// Outside reset nothing reloads the values [RULE14]
			if (WR_EN) begin
				if (WR_IDX <= `RSF_GEN_LAST) begin
					s_d.gen[WR_IDX] = WR_DATA;
				end else if (WR_IDX == `RSF_LOWVOLT_CONTROL_IDX) begin
					s_d.lv_ctrl = WR_DATA;
				end else if (WR_IDX == `RSF_LOWVOLT_LEVEL_SEL_IDX) begin
					s_d.lv_level = WR_DATA;
				end
			end
			if (RD_EN) begin
				if (RD_IDX <= `RSF_GEN_LAST) begin
					s_d.rd_data = s_q.gen[RD_IDX];
				end else if (RD_IDX == `RSF_RESET_SOURCE_FLAGS_IDX) begin
					s_d.rd_data = flag_byte(s_q.wdt_flag, s_q.lvi_flag);
					s_d.wdt_flag = 1'b0; // [RULE18]
					s_d.lvi_flag = 1'b0; // [RULE18]
				end else if (RD_IDX == `RSF_LOWVOLT_CONTROL_IDX) begin
					s_d.rd_data = s_q.lv_ctrl;
				end else if (RD_IDX == `RSF_LOWVOLT_LEVEL_SEL_IDX) begin
					s_d.rd_data = s_q.lv_level;
				end else begin
					s_d.rd_data = `RSF_ZERO;
				end
			end
		end
	end

	always_ff @(posedge CORE_CLK) begin
		s_q <= s_d;
	end

	// ======================================================
	// Outputs
	assign RD_DATA = s_q.rd_data;
	assign RESET_ACTIVE = s_q.rst_active;
	assign WATCHDOG_RESET_FLAG = s_q.wdt_flag;
	assign LOWVOLT_RESET_FLAG = s_q.lvi_flag;
	assign LOWVOLT_CONTROL = s_q.lv_ctrl;
	assign LOWVOLT_LEVEL_SEL = s_q.lv_level;
endmodule

// [hdl/rsf_sync.sv]
`timescale 1ns/100ps
module rsf_sync #(
	parameter int WIDTH = 3
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	typedef struct packed {
		logic [WIDTH-1:0] s1;
		logic [WIDTH-1:0] s2;
		logic [WIDTH-1:0] s3;
		logic [WIDTH-1:0] out;
	} rsf_sync_st_s;

	rsf_sync_st_s s_q;
	rsf_sync_st_s s_d;

	// ======================================================
	// Three stages; a level counts once stages two and three agree
	always_comb begin
		s_d = s_q;
		s_d.s1 = async_in;
		s_d.s2 = s_q.s1;
		s_d.s3 = s_q.s2;
		for (int i = 0; i < WIDTH; i++) begin
			if (s_q.s2[i] == s_q.s3[i]) begin
				s_d.out[i] = s_q.s3[i];
			end
		end
		// Reset preloads the live level, so a strap such as the
		// watchdog option is already valid before reset lets go
		if (srst) begin
			s_d.s1 = async_in;
			s_d.s2 = async_in;
			s_d.s3 = async_in;
			s_d.out = async_in;
		end
	end

	always_ff @(posedge clk) begin
		s_q <= s_d;
	end

	assign sync_out = s_q.out;
endmodule

// [test/rsf_properties.sv]
`timescale 1ns/100ps
// ========
// Reset flag checks
module rsf_properties (
	input wire logic CORE_CLK,
	input wire logic SRST,
	input wire logic WR_EN,
	input wire logic [6:0] WR_IDX,
	input wire logic RD_EN,
	input wire logic [6:0] RD_IDX,
	input wire logic [7:0] RD_DATA,
	input wire logic RESET_ACTIVE,
	input wire logic WATCHDOG_RESET_FLAG,
	input wire logic LOWVOLT_RESET_FLAG,
	input wire logic [7:0] LOWVOLT_CONTROL,
	input wire logic [7:0] LOWVOLT_LEVEL_SEL
);
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (SRST);
	wire logic rdf = RD_EN && RD_IDX == 7'h53 && !RESET_ACTIVE;
	wire logic wlv = WR_EN && WR_IDX == 7'h54;
	property p_wdt;
		$rose(WATCHDOG_RESET_FLAG) |-> RESET_ACTIVE && !LOWVOLT_CONTROL;
	endproperty
	a_wdt: assert property (p_wdt) else $error("wdt");
	property p_lvi;
		$rose(LOWVOLT_RESET_FLAG) |-> RESET_ACTIVE && $stable(LOWVOLT_CONTROL);
	endproperty
	a_lvi: assert property (p_lvi) else $error("lvi");
	property p_rel;
		$fell(SRST) |-> RESET_ACTIVE && !WATCHDOG_RESET_FLAG &&
			!LOWVOLT_RESET_FLAG;
	endproperty
	a_rel: assert property (p_rel) else $error("rel");
	property p_rel_lv;
		$fell(SRST) |-> !LOWVOLT_CONTROL && !LOWVOLT_LEVEL_SEL;
	endproperty
	a_rel_lv: assert property (p_rel_lv) else $error("rel lv");
	property p_rdv;
		rdf |=> RD_DATA == {3'h0, $past(WATCHDOG_RESET_FLAG), 3'h0,
			$past(LOWVOLT_RESET_FLAG)};
	endproperty
	a_rdv: assert property (p_rdv) else $error("rdv");
	property p_rdc;
		rdf |=> !WATCHDOG_RESET_FLAG && !LOWVOLT_RESET_FLAG;
	endproperty
	a_rdc: assert property (p_rdc) else $error("rdc");
	property p_lvh;
		$changed(LOWVOLT_CONTROL) |-> RESET_ACTIVE || $past(wlv);
	endproperty
	a_lvh: assert property (p_lvh) else $error("lvh");
	property p_rdh;
		!RD_EN && !RESET_ACTIVE |=> $stable(RD_DATA) || RESET_ACTIVE;
	endproperty
	a_rdh: assert property (p_rdh) else $error("rdh");
	c_wdt: cover property ($rose(WATCHDOG_RESET_FLAG));
	c_lvi: cover property ($rose(LOWVOLT_RESET_FLAG));
	c_rd: cover property (rdf && WATCHDOG_RESET_FLAG);
endmodule

// [test/rsf_src_model.sv]
`timescale 1ns/100ps
// ========
// Reset sources: 0 pin, 1 power, 2 watchdog, 3 low voltage
module rsf_src_model (
	input wire logic clk,
	output logic [3:0] src
);
	initial src = 4'h0;
	// Held well past the input filter so the request is never lost
	task automatic fire(input int k);
		@(posedge clk);
		#1 src[k] = 1'b1;
		repeat (8) @(posedge clk);
		#1 src[k] = 1'b0;
	endtask
endmodule

// [test/tb.sv]
`timescale 1ns/100ps
// ========
// Bench
module tb;
	logic CORE_CLK = 0, SRST = 1, WATCHDOG_ENABLE_REG_OPTION = 0, WR_EN = 0, RD_EN = 0;
	logic [6:0] WR_IDX = 0, RD_IDX = 0;
	logic [7:0] WR_DATA = 0;
	wire logic [7:0] RD_DATA, LOWVOLT_CONTROL, LOWVOLT_LEVEL_SEL;
	wire logic [3:0] src;
	wire logic RESET_ACTIVE, WATCHDOG_RESET_FLAG, LOWVOLT_RESET_FLAG;
	int err_total = 0, cmp_count = 0;
	rsf_src_model i_rsf_src_model (.clk(CORE_CLK), .src(src));
	rsf_reset_values i_rsf_reset_values (.CORE_CLK, .SRST,
		.PIN_RESET(src[0]), .POWER_ON_CLEAR(src[1]), .WATCHDOG_UNIT(src[2]),
		.LOWVOLT_DETECTOR(src[3]), .WATCHDOG_ENABLE_REG_OPTION, .WR_EN, .WR_IDX, .WR_DATA,
		.RD_EN, .RD_IDX, .RD_DATA, .RESET_ACTIVE, .WATCHDOG_RESET_FLAG,
		.LOWVOLT_RESET_FLAG, .LOWVOLT_CONTROL, .LOWVOLT_LEVEL_SEL);
	initial forever #5 CORE_CLK = ~CORE_CLK;
	task automatic final_report;
		$display("errors %0d compares %0d", err_total, cmp_count);
		if (err_total == 0 && cmp_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [6:0] i, input logic [7:0] d);
		@(posedge CORE_CLK);
		#1 WR_EN = 1; WR_IDX = i; WR_DATA = d;
		@(posedge CORE_CLK);
		#1 WR_EN = 0;
	endtask
	task automatic rd(input logic [6:0] i, input logic [7:0] e);
		@(posedge CORE_CLK);
		#1 RD_EN = 1; RD_IDX = i;
		@(posedge CORE_CLK);
		#1 RD_EN = 0;
		chk(RD_DATA, e);
	endtask
	task automatic flags(input logic [7:0] e);
		chk({3'h0, WATCHDOG_RESET_FLAG, 3'h0, LOWVOLT_RESET_FLAG}, e);
	endtask
	// Source release passes the filter and a register before showing
	task automatic hit(input int k);
		i_rsf_src_model.fire(k);
		repeat (6) @(posedge CORE_CLK);
		#1;
		for (int n = 0; RESET_ACTIVE !== 1'b0; n++) begin
			if (n == 20) begin
				err_total++;
				final_report();
			end
			@(posedge CORE_CLK);
			#1;
		end
	endtask
	function automatic logic [7:0] expv(input logic [6:0] i, input logic o);
		case (i)
			7'h11: return o ? 8'h9a : 8'h1a;
			7'h18, 7'h19, 7'h1d, 7'h1e, 7'h23: return 8'hff;
			7'h1a, 7'h1f: return 8'h01;
			7'h1c: return 8'h1f;
			7'h24: return 8'h16;
			7'h31: return 8'h03;
			default: return (i >= 7'h49 && i <= 7'h50) ? 8'hff : 8'h00;
		endcase
	endfunction
	task automatic t_defaults(input logic o);
		for (int i = 0; i < 128; i++)
			rd(7'(i), expv(7'(i), o));
	endtask
	task automatic t_wdt_lvi;
		wr(7'h00, 8'h5a);
		wr(7'h54, 8'h33);
		wr(7'h55, 8'h44);
		hit(2);
		rd(7'h00, 8'h00);
		flags(8'h10);
		chk(LOWVOLT_CONTROL | LOWVOLT_LEVEL_SEL, 8'h00);
		wr(7'h54, 8'h33);
		hit(3);
		flags(8'h11);
		chk(LOWVOLT_CONTROL, 8'h33);
		hit(2);
		flags(8'h11);
		chk(LOWVOLT_CONTROL, 8'h00);
	endtask
	task automatic t_read_clear;
		rd(7'h53, 8'h11);
		rd(7'h53, 8'h00);
		hit(2);
		wr(7'h53, 8'hff);
		rd(7'h53, 8'h10);
	endtask
	task automatic t_pin_poc;
		for (int k = 0; k < 2; k++) begin
			hit(2);
			hit(3);
			wr(7'h54, 8'h33);
			hit(k);
			flags(8'h00);
			chk(LOWVOLT_CONTROL, 8'h00);
		end
	endtask
	initial begin
		repeat (2) @(posedge CORE_CLK);
		#1 SRST = 0;
		t_defaults(1'b0);
		t_wdt_lvi();
		t_read_clear();
		t_pin_poc();
		WATCHDOG_ENABLE_REG_OPTION = 1;
		repeat (5) @(posedge CORE_CLK);
		#1 SRST = 1;
		repeat (2) @(posedge CORE_CLK);
		#1 SRST = 0;
		t_defaults(1'b1);
		final_report();
	end
endmodule
bind rsf_reset_values rsf_properties i_rsf_properties (.CORE_CLK, .SRST,
	.WR_EN, .WR_IDX, .RD_EN, .RD_IDX, .RD_DATA, .RESET_ACTIVE,
	.WATCHDOG_RESET_FLAG, .LOWVOLT_RESET_FLAG, .LOWVOLT_CONTROL,
	.LOWVOLT_LEVEL_SEL);
